// ### mme_exec.v
// Execution of store-working-to-file and the two multiply instructions.
// Assumes a decoder presenting one instruction word per four-quarter cycle
// and a banked file that returns read data combinationally.
`timescale 1ns/1ns
`include "mme_map.vh"
module mme_exec #(
  parameter DW = 8,
  parameter BW = 4
) (
  input  wire          mclk,
  input  wire          resetn,
  input  wire [15:0]   instr_word,
  input  wire          instr_valid,
  input  wire [DW-1:0] working_register,
  input  wire [BW-1:0] bank_select_register,
  input  wire [DW-1:0] file_rdata,
  input  wire [4:0]    status_in,
  output reg  [BW+7:0] file_addr,
  output reg           file_rd,
  output reg           file_we,
  output reg  [DW-1:0] file_wdata,
  output reg  [DW-1:0] product_high,
  output reg  [DW-1:0] product_low,
  output reg           prod_we,
  output reg  [4:0]    status_out,
  output reg           status_we,
  output reg  [1:0]    quarter
);
  // Quarter codes of the instruction cycle
  localparam [1:0] Q_DECODE  = `MME_Q1;
  localparam [1:0] Q_READ    = `MME_Q2;
  localparam [1:0] Q_PROCESS = `MME_Q3;
  localparam [1:0] Q_WRITE   = `MME_Q4;
  localparam       PW        = 2 * DW;

  wire            is_store;
  wire            is_mulf;
  wire            is_mull;
  wire            is_mul;
  wire            use_bsr;
  wire            acc_low;
  wire [7:0]      f_addr;
  wire [BW-1:0]   acc_bank;
  wire [BW-1:0]   bank_sel;
  wire [BW+7:0]   addr_nxt;
  wire [PW-1:0]   prod;
  reg  [15:0]     op_r;
  reg  [15:0]     op_nxt;
  reg             op_v_r;
  reg             op_v_nxt;
  reg  [DW-1:0]   opnd_r;
  reg  [DW-1:0]   opnd_nxt;
  reg  [1:0]      quarter_nxt;

  // Free running phase counter; every instruction takes four edges
  always @* begin
    quarter_nxt = quarter + 2'h1;
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      quarter <= `MME_Q1;
    end else begin
      quarter <= quarter_nxt;
    end
  end

  // Word is latched at the end of the decode quarter; the valid mark
  // is dropped after the write quarter so nothing repeats
  always @* begin
    op_nxt   = op_r;
    op_v_nxt = op_v_r;
    case (quarter)
      Q_DECODE: begin
        op_nxt   = instr_word;
        op_v_nxt = instr_valid;
      end
      Q_READ: begin
        op_v_nxt = op_v_r;
      end
      Q_PROCESS: begin
        op_v_nxt = op_v_r;
      end
      Q_WRITE: begin
        op_v_nxt = 1'b0;
      end
      default: begin
        op_v_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      op_r   <= 16'h0000;
      op_v_r <= 1'b0;
    end else begin
      op_r   <= op_nxt;
      op_v_r <= op_v_nxt;
    end
  end

  // Decode of the three handled opcodes; anything else raises no strobe, though its offset still reaches file_addr
  assign is_store = op_v_r && (op_r[15:9] == `MME_OPC_STORE_HI);
  assign is_mulf  = op_v_r && (op_r[15:9] == `MME_OPC_MULF_HI);
  assign is_mull  = op_v_r && (op_r[15:8] == `MME_OPC_MULL);
  assign is_mul   = is_mull || is_mulf;

  assign use_bsr  = op_r[`MME_ACCESS_BIT];
  assign f_addr   = op_r[7:0];

  // Access bank: low offsets from bank 0, high offsets from the top
  // bank, so one window reaches common data without a bank change
  assign acc_low  = (f_addr <= `MME_ACC_LOW_TOP);
  assign acc_bank = acc_low ? `MME_ACC_LOW_BANK : `MME_ACC_HIGH_BANK;
  assign bank_sel = use_bsr ? bank_select_register : acc_bank;
  assign addr_nxt = {bank_sel, f_addr};

  // Address holds until the next read quarter; the read strobe lasts
  // one quarter and only the file multiply raises it
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      file_addr <= {(BW+8){1'b0}};
      file_rd   <= 1'b0;
    end else begin
      file_rd <= 1'b0;
      if (quarter == Q_READ) begin
        file_addr <= addr_nxt;
        file_rd   <= is_mulf;
      end
    end
  end

  // Second operand: the literal in the read quarter, or the file byte
  // at the end of the process quarter while the strobe stands
  always @* begin
    opnd_nxt = opnd_r;
    case (quarter)
      Q_READ: begin
        if (is_mull) begin
          opnd_nxt = op_r[7:0];
        end
      end
      Q_PROCESS: begin
        if (is_mulf) begin
          opnd_nxt = file_rdata;
        end
      end
      default: begin
        opnd_nxt = opnd_r;
      end
    endcase
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      opnd_r <= `MME_BYTE_RST;
    end else begin
      opnd_r <= opnd_nxt;
    end
  end

  // Working register is only read here, never driven back
  mme_mul8 #(
    .W (DW)
  ) u_mul (
    .a (working_register),
    .b (opnd_r),
    .p (prod)
  );

  // Store result is registered at the end of the write quarter as a one-clock strobe
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      file_wdata <= `MME_BYTE_RST;
      file_we    <= 1'b0;
    end else begin
      file_we <= 1'b0;
      if ((quarter == Q_WRITE) && is_store) begin
        file_wdata <= working_register;
        file_we    <= 1'b1;
      end
    end
  end

  // Product pair is written together so no half-updated pair is seen
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      product_high <= `MME_BYTE_RST;
      product_low  <= `MME_BYTE_RST;
    end else begin
      if ((quarter == Q_WRITE) && is_mul) begin
        product_high <= prod[PW-1:DW];
        product_low  <= prod[DW-1:0];
      end
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prod_we <= 1'b0;
    end else begin
      prod_we <= (quarter == Q_WRITE) && is_mul;
    end
  end

  // Flags are only echoed; none of these instructions may write them
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_out <= 5'h00;
      status_we  <= 1'b0;
    end else begin
      status_out <= status_in;
      status_we  <= 1'b0;
    end
  end

endmodule // mme_exec

// ### mme_map.vh
// Constants for the move and multiply execution block.
// Assumes inclusion by mme_exec.v only; mme_mul8.v does not include it.
`ifndef MME_MAP_VH
`define MME_MAP_VH
`define MME_OPC_STORE_HI   7'h37
`define MME_OPC_MULF_HI    7'h01
`define MME_OPC_MULL       8'h0D
`define MME_OPC_LOADL      8'h0E
`define MME_ACCESS_BIT     8
`define MME_Q1             2'h0
`define MME_Q2             2'h1
`define MME_Q3             2'h2
`define MME_Q4             2'h3
`define MME_ACC_LOW_TOP    8'h7F
`define MME_ACC_LOW_BANK   4'h0
`define MME_ACC_HIGH_BANK  4'hF
`define MME_BYTE_RST       8'h00
`define MME_PROD_RST       16'h0000
`endif

// ### mme_mul8.v
// Unsigned combinational 8 by 8 multiplier.
// Assumes the caller registers the product.
`timescale 1ns/1ns
module mme_mul8 #(
  parameter W = 8
) (
  input  wire [W-1:0]   a,
  input  wire [W-1:0]   b,
  output wire [2*W-1:0] p
);
  assign p = a * b;
endmodule // mme_mul8

// ### mme_file_model.sv
// Banked register file model facing mme_exec.
// Assumes file_addr is {bank, offset} and reads are combinational.
`timescale 1ns/1ns
module mme_file_model (input wire mclk, file_rd, file_we,
  input wire [11:0] file_addr, input wire [7:0] file_wdata,
  output wire [7:0] file_rdata);
  reg [7:0] mem [0:4095];
  // Inverse outside a read strobe, so stale data never looks right
  assign file_rdata = file_rd ? mem[file_addr] : ~mem[file_addr];
  always @(posedge mclk) if (file_we) mem[file_addr] <= file_wdata;
endmodule // mme_file_model

// ### mme_exec_properties.sv
// Port timing checks for mme_exec.
// Assumes one clock; bound to every mme_exec.
`timescale 1ns/1ns
module mme_props (input wire mclk, resetn, instr_valid, file_rd, file_we,
  prod_we, status_we, input wire [1:0] quarter, input wire [15:0] instr_word,
  input wire [3:0] bank_select_register, input wire [11:0] file_addr,
  input wire [7:0] working_register, file_rdata, file_wdata, product_high,
  product_low, input wire [4:0] status_in, status_out);
  wire go = instr_valid && quarter == 2'h0;
  wire st = go && instr_word[15:9] == 7'h37;
  wire mf = go && instr_word[15:9] == 7'h01;
  wire [15:0] pr = {product_high, product_low};
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_phase_step:
  assert property (1 |=> quarter == $past(quarter) + 2'h1) else $error("q");
  a_store_data:
  assert property (st |-> ##4 file_we && file_wdata == $past(working_register))
    else $error("s");
  a_file_offset:
  assert property (st || mf |-> ##2 file_addr[7:0] == $past(instr_word[7:0],2))
    else $error("o");
  a_bank_select:
  assert property (mf && instr_word[8] |-> ##2 file_addr[11:8] ==
    $past(bank_select_register, 2)) else $error("b");
  a_mull_prod:
  assert property (go && instr_word[15:8] == 8'h0D |-> ##4 prod_we &&
    pr == $past(working_register, 4) * $past(instr_word[7:0], 4))
    else $error("l");
  a_mulf_read:
  assert property (mf |-> ##2 file_rd) else $error("r");
  a_mulf_prod:
  assert property (mf |-> ##4 prod_we &&
    pr == $past(working_register) * $past(file_rdata, 2)) else $error("f");
  a_flags_kept:
  assert property (!status_we) else $error("z");
  a_flags_echo:
  assert property ($past(resetn) |-> status_out == $past(status_in))
    else $error("e");
  cover property (st);
  cover property (mf);
  cover property (prod_we);
endmodule // mme_props
bind mme_exec mme_props u_props (.*);

// ### tb_top.sv
// Self-checking bench for mme_exec over a file model.
// Assumes mme_props is bound into the design.
`timescale 1ns/1ns
module tb_top;
  logic mclk = 0, resetn = 0, instr_valid = 0, file_rd, file_we, prod_we;
  logic status_we;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] working_register = 8'h00, file_rdata, file_wdata;
  logic [7:0] product_high, product_low;
  logic [3:0] bank_select_register = 4'h5;
  logic [4:0] status_in = 5'h15, status_out;
  logic [11:0] file_addr;
  logic [1:0] quarter;
  int err_total = 0, total_checks = 0;
  mme_exec uut (.*);
  mme_file_model u_file (.*);
  initial forever #10 mclk = ~mclk;
  task wrap_up;
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(logic [15:0] s, e);
    total_checks++;
    if (s !== e) err_total++;
    if (s !== e) $display("ERROR %0t %h %h", $time, s, e);
  endtask
  // Issues one word so it is captured at the next quarter-zero edge
  task run(logic [15:0] w, logic v, logic [7:0] d);
    repeat (4) if (quarter !== 2'h3) @(negedge mclk);
    if (quarter !== 2'h3) err_total++;
    if (quarter !== 2'h3) wrap_up;
    @(posedge mclk);
    instr_word <= w;
    instr_valid <= v;
    working_register <= d;
    @(posedge mclk);
    instr_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task t_store;
    run(16'h6F33, 1'b1, 8'h4F);
    chk({file_we, 3'h0, file_addr}, 16'h8533);
    chk({status_we,2'h0,status_out,file_wdata}, 16'h154F);
    run(16'h6E85, 1'b1, 8'hA7);
    chk({file_we, 3'h0, file_addr}, 16'h8F85);
    chk({8'h00, u_file.mem[12'h533]}, 16'h004F);
    run(16'h6E20, 1'b1, 8'h11);
    chk({file_we, 3'h0, file_addr}, 16'h8020);
    run(16'h6F40, 1'b0, 8'h99);
    chk({file_we, prod_we, 14'h0000}, 16'h0000);
  endtask
  task t_mul;
    u_file.mem[12'h5B5] = 8'hB5;
    run(16'h0DC4, 1'b1, 8'hE2);
    chk({product_high, product_low}, 16'hAD08);
    run(16'h03B5, 1'b1, 8'hC4);
    chk({product_high, product_low}, 16'h8A94);
    chk({prod_we,status_we,6'h00,u_file.mem[12'h5B5]}, 16'h80B5);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_store;
    t_mul;
    wrap_up;
  end
endmodule // tb_top
